// ### logic/dxr_regs.sv
// Power, timing, audio and link status register bank of the display receiver
`timescale 1ns/1ps
`include "dxr_defs.svh"

module dxr_regs
  import dxr_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  output logic                  reg_rvalid,
  input  wire logic             power_down_pin,
  input  wire logic             sync_present,
  input  wire dxr_status_s      status_in,
  input  wire logic             hsync_in,
  input  wire logic             vsync_in,
  input  wire logic             field_in,
  output logic                  low_power,
  output logic                  video_oe_b,
  output logic                  green_sync_oe_b,
  output dxr_config_s           config_out,
  output logic                  de_gen,
  output logic                  active_video_start_marker,
  output logic                  active_video_end_marker
);

  // ==========================================================
  // Register storage
  logic [7:0]  pwr_q, auto_q, vdly_q, hdlyl_q, lwh_q, lwl_q, shh_q, shl_q, aud_q;
  dxr_status_s stat_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_q   <= `DXR_RST_PWR_CFG;
      auto_q  <= `DXR_RST_AUTO_MODE;
      vdly_q  <= `DXR_RST_VDLY_HDLYH;
      hdlyl_q <= `DXR_RST_HDLY_LOW;
      lwh_q   <= `DXR_RST_LWID_HIGH;
      lwl_q   <= `DXR_RST_LWID_LOW;
      shh_q   <= `DXR_RST_SHGT_HIGH;
      shl_q   <= `DXR_RST_SHGT_LOW;
      aud_q   <= `DXR_RST_AUD_FMT;
    end else if (reg_wr) begin
      // Status offsets have no write path at all
      if (reg_addr == `DXR_OFS_PWR_CFG) begin
        pwr_q <= reg_wdata;
      end else if (reg_addr == `DXR_OFS_AUTO_MODE) begin
        auto_q <= reg_wdata;
      end else if (reg_addr == `DXR_OFS_VDLY_HDLYH) begin
        vdly_q <= reg_wdata;
      end else if (reg_addr == `DXR_OFS_HDLY_LOW) begin
        hdlyl_q <= reg_wdata;
      end else if (reg_addr == `DXR_OFS_LWID_HIGH) begin
        lwh_q <= reg_wdata;
      end else if (reg_addr == `DXR_OFS_LWID_LOW) begin
        lwl_q <= reg_wdata;
      end else if (reg_addr == `DXR_OFS_SHGT_HIGH) begin
        shh_q <= reg_wdata;
      end else if (reg_addr == `DXR_OFS_SHGT_LOW) begin
        shl_q <= reg_wdata;
      end else if (reg_addr == `DXR_OFS_AUD_FMT) begin
        aud_q <= reg_wdata;
      end
    end
  end

  // Status snapshot from the receiver core; not writable by software
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= '0;
    end else begin
      stat_q <= status_in;
    end
  end

  // ==========================================================
  // Read path
  logic [7:0] stat_a, stat_b, rd_d;

  assign stat_a = {1'b0, stat_q.tmds_de_seen, stat_q.tmds_clk_seen, stat_q.av_muted,
                   stat_q.keys_read_ok, stat_q.link_quality};
  assign stat_b = {1'b0, stat_q.decrypt_active, stat_q.hsync_high_active,
                   stat_q.vsync_high_active, stat_q.pixel_repeat};

  always_comb begin
    if (reg_addr == `DXR_OFS_PWR_CFG) begin
      rd_d = {4'h0, pwr_q[`DXR_PWR_POL_BIT:0]};
    end else if (reg_addr == `DXR_OFS_AUTO_MODE) begin
      rd_d = auto_q;
    end else if (reg_addr == `DXR_OFS_VDLY_HDLYH) begin
      rd_d = vdly_q;
    end else if (reg_addr == `DXR_OFS_HDLY_LOW) begin
      rd_d = hdlyl_q;
    end else if (reg_addr == `DXR_OFS_LWID_HIGH) begin
      rd_d = {4'h0, lwh_q[`DXR_HIGH_NIB_HI:0]};
    end else if (reg_addr == `DXR_OFS_LWID_LOW) begin
      rd_d = lwl_q;
    end else if (reg_addr == `DXR_OFS_SHGT_HIGH) begin
      rd_d = {4'h0, shh_q[`DXR_HIGH_NIB_HI:0]};
    end else if (reg_addr == `DXR_OFS_SHGT_LOW) begin
      rd_d = shl_q;
    end else if (reg_addr == `DXR_OFS_AUD_FMT) begin
      rd_d = aud_q;
    end else if (reg_addr == `DXR_OFS_STAT_A) begin
      rd_d = stat_a;
    end else if (reg_addr == `DXR_OFS_STAT_B) begin
      rd_d = stat_b;
    end else begin
      rd_d = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_d;
      end
    end
  end

  // ==========================================================
  // Power control
  logic       pin_active, pd_d, vid_float_d, green_float_d;
  logic [1:0] pin_fn;

  assign pin_fn        = pwr_q[`DXR_PWR_FN_HI:`DXR_PWR_FN_LO];
  assign pin_active    = (power_down_pin == pwr_q[`DXR_PWR_POL_BIT]);
  // Sync detection stays alive in power-down, so auto power-down releases itself
  assign pd_d          = pwr_q[`DXR_PWR_SW_BIT]
                       | (pin_active & ~pin_fn[`DXR_FN_KEEP_BIT])
                       | (auto_q[`DXR_AUTO_PD_BIT] & ~sync_present);
  assign vid_float_d   = pd_d | pin_active;
  assign green_float_d = pin_active & pin_fn[`DXR_FN_ALL_BIT];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_power       <= 1'b0;
      video_oe_b      <= 1'b1;
      green_sync_oe_b <= 1'b1;
    end else begin
      low_power       <= pd_d;
      video_oe_b      <= vid_float_d;
      green_sync_oe_b <= green_float_d;
    end
  end

  // ==========================================================
  // Configuration outputs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      config_out <= '0;
    end else begin
      config_out.hdcp_addr_lsb      <= auto_q[`DXR_HDCP_LSB_BIT];
      config_out.mclk_external      <= auto_q[`DXR_MCLK_EXT_BIT];
      config_out.bt656_enable       <= auto_q[`DXR_BT656_BIT];
      config_out.force_de           <= auto_q[`DXR_FORCE_DE_BIT];
      config_out.ctrl_on_audio_pins <= aud_q[`DXR_CTRL_OUT_BIT];
      config_out.audio_format       <= aud_q[`DXR_AUD_MODE_HI:`DXR_AUD_MODE_LO];
      config_out.audio_word_width   <= aud_q[`DXR_AUD_WIDTH_HI:0];
    end
  end

  // ==========================================================
  // Active video timing generator
  logic [CNT_W-1:0] h_cnt_q, v_cnt_q, hdly, vdly, lwid, shgt, h_end, v_beg, v_end;
  logic             hs_q, vs_q, hs_rise, vs_rise, h_act, v_act;

  assign hdly    = CNT_W'({vdly_q[`DXR_HDLYH_HI:0], hdlyl_q});
  assign vdly    = CNT_W'(vdly_q[`DXR_VDLY_HI:`DXR_VDLY_LO]);
  assign lwid    = CNT_W'({lwh_q[`DXR_HIGH_NIB_HI:0], lwl_q});
  assign shgt    = CNT_W'({shh_q[`DXR_HIGH_NIB_HI:0], shl_q});
  assign h_end   = hdly + lwid;
  // Field 1 starts later by the interlace offset
  assign v_beg   = vdly + (field_in ? CNT_W'(auto_q[`DXR_ILACE_HI:0]) : '0);
  assign v_end   = v_beg + shgt;
  assign hs_rise = hsync_in & ~hs_q;
  assign vs_rise = vsync_in & ~vs_q;
  assign h_act   = (h_cnt_q >= hdly) && (h_cnt_q < h_end);
  assign v_act   = (v_cnt_q >= v_beg) && (v_cnt_q < v_end);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_q <= 1'b0;
      vs_q <= 1'b0;
    end else begin
      hs_q <= hsync_in;
      vs_q <= vsync_in;
    end
  end

  // Counters saturate so a missing sync never wraps into a false window
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      h_cnt_q <= '0;
      v_cnt_q <= '0;
    end else begin
      if (hs_rise) begin
        h_cnt_q <= '0;
      end else if (h_cnt_q != '1) begin
        h_cnt_q <= h_cnt_q + 1'b1;
      end
      if (vs_rise) begin
        v_cnt_q <= '0;
      end else if (hs_rise && v_cnt_q != '1) begin
        v_cnt_q <= v_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      de_gen                    <= 1'b0;
      active_video_start_marker <= 1'b0;
      active_video_end_marker   <= 1'b0;
    end else begin
      de_gen                    <= auto_q[`DXR_FORCE_DE_BIT] & h_act & v_act;
      active_video_start_marker <= auto_q[`DXR_BT656_BIT] & v_act & (h_cnt_q == hdly) & ~hs_rise;
      active_video_end_marker   <= auto_q[`DXR_BT656_BIT] & v_act & (h_cnt_q == h_end) & ~hs_rise;
    end
  end

  // ==========================================================
  // Checks
  a_sw_pd_floats: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pwr_q[`DXR_PWR_SW_BIT] |=> (low_power && video_oe_b))
    else $error("software power-down did not float video outputs");

  a_pin_polarity: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (power_down_pin != pwr_q[`DXR_PWR_POL_BIT]) && !pwr_q[`DXR_PWR_SW_BIT] && sync_present
      |=> !low_power && !video_oe_b && !green_sync_oe_b)
    else $error("inactive power-down pin still affected outputs");

  a_pin_function: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (power_down_pin == pwr_q[`DXR_PWR_POL_BIT]) && !pwr_q[`DXR_PWR_SW_BIT] && sync_present
      |=> video_oe_b && (low_power == !$past(pin_fn[`DXR_FN_KEEP_BIT]))
        && (green_sync_oe_b == $past(pin_fn[`DXR_FN_ALL_BIT])))
    else $error("power-down pin function mismatch");

  a_auto_pd: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !sync_present |=> (low_power == $past(auto_q[`DXR_AUTO_PD_BIT] | pd_d)))
    else $error("auto power-down did not follow sync loss");

  a_status_ro: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_rd && reg_addr == `DXR_OFS_STAT_B |=> reg_rvalid && reg_rdata == {1'b0, $past(stat_q.decrypt_active),
      $past(stat_q.hsync_high_active), $past(stat_q.vsync_high_active), $past(stat_q.pixel_repeat)})
    else $error("status read does not show live status");

  a_de_window: assert property (@(posedge ref_clk) disable iff (!rst_b)
    de_gen |-> $past(auto_q[`DXR_FORCE_DE_BIT]) && $past(h_cnt_q) >= $past(hdly))
    else $error("generated DE outside programmed window");

  a_marker_mode: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (active_video_start_marker || active_video_end_marker) |-> $past(auto_q[`DXR_BT656_BIT]))
    else $error("marker emitted while BT656 disabled");

  a_cfg_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && reg_addr == `DXR_OFS_AUD_FMT ##1 !reg_wr [*2]
      |-> config_out.audio_word_width == $past(aud_q[`DXR_AUD_WIDTH_HI:0])
        && config_out.mclk_external == $past(auto_q[`DXR_MCLK_EXT_BIT]))
    else $error("audio configuration did not follow write");

endmodule // dxr_regs

// ### logic/dxr_defs.svh
// Offsets, field positions and reset values of the display receiver register bank
`ifndef DXR_DEFS_SVH
`define DXR_DEFS_SVH

// ==========================================================
// Register offsets
`define DXR_OFS_PWR_CFG     8'h26
`define DXR_OFS_AUTO_MODE   8'h27
`define DXR_OFS_VDLY_HDLYH  8'h28
`define DXR_OFS_HDLY_LOW    8'h29
`define DXR_OFS_LWID_HIGH   8'h2A
`define DXR_OFS_LWID_LOW    8'h2B
`define DXR_OFS_SHGT_HIGH   8'h2C
`define DXR_OFS_SHGT_LOW    8'h2D
`define DXR_OFS_AUD_FMT     8'h2E
`define DXR_OFS_STAT_A      8'h2F
`define DXR_OFS_STAT_B      8'h30

// ==========================================================
// Reset values
`define DXR_RST_PWR_CFG     8'h08
`define DXR_RST_AUTO_MODE   8'h80
`define DXR_RST_VDLY_HDLYH  8'h61
`define DXR_RST_HDLY_LOW    8'h04
`define DXR_RST_LWID_HIGH   8'h05
`define DXR_RST_LWID_LOW    8'h00
`define DXR_RST_SHGT_HIGH   8'h02
`define DXR_RST_SHGT_LOW    8'hD0
`define DXR_RST_AUD_FMT     8'h18

// ==========================================================
// Field positions
`define DXR_PWR_POL_BIT     3
`define DXR_PWR_FN_HI       2
`define DXR_PWR_FN_LO       1
`define DXR_PWR_SW_BIT      0
`define DXR_AUTO_PD_BIT     7
`define DXR_HDCP_LSB_BIT    6
`define DXR_MCLK_EXT_BIT    5
`define DXR_BT656_BIT       4
`define DXR_FORCE_DE_BIT    3
`define DXR_ILACE_HI        2
`define DXR_VDLY_HI         7
`define DXR_VDLY_LO         2
`define DXR_HDLYH_HI        1
`define DXR_HIGH_NIB_HI     3
`define DXR_CTRL_OUT_BIT    7
`define DXR_AUD_MODE_HI     6
`define DXR_AUD_MODE_LO     5
`define DXR_AUD_WIDTH_HI    4

// Pin function codes: bit 1 keeps the part powered, bit 0 also floats green sync
`define DXR_FN_KEEP_BIT     1
`define DXR_FN_ALL_BIT      0

`endif

// ### logic/dxr_pkg.sv
// Types shared by the display receiver register bank
package dxr_pkg;

  // ==========================================================
  // Link status inputs from the receiver core
  typedef struct packed {
    logic       tmds_de_seen;
    logic       tmds_clk_seen;
    logic       av_muted;
    logic       keys_read_ok;
    logic [2:0] link_quality;
    logic       decrypt_active;
    logic       hsync_high_active;
    logic       vsync_high_active;
    logic [3:0] pixel_repeat;
  } dxr_status_s;

  // ==========================================================
  // Configuration outputs to the rest of the chip
  typedef struct packed {
    logic       hdcp_addr_lsb;
    logic       mclk_external;
    logic       bt656_enable;
    logic       force_de;
    logic       ctrl_on_audio_pins;
    logic [1:0] audio_format;
    logic [4:0] audio_word_width;
  } dxr_config_s;

endpackage

// ### bench/dxr_host.sv
// Host controller model that drives the register strobe port
`timescale 1ns/1ps
module dxr_host (
  input  wire logic       ref_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // ==========================================================
  // Bus cycles, launched on the falling edge
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    // Released lines show a changed value so stale data is never mistaken for live
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask

  // Status is polled on request, never cached by the host
  task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    @(negedge ref_clk);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    reg_rd   = 1'b0;
    reg_addr = ~addr;
    ok       = 1'b0;
    data     = 8'h00;
    for (n = 0; n < 4 && ok == 1'b0; n++) begin
      if (reg_rvalid === 1'b1) begin
        data = reg_rdata;
        ok   = 1'b1;
      end else begin
        @(negedge ref_clk);
      end
    end
  endtask
endmodule // dxr_host

// ### bench/testbench.sv
// Self-checking testbench of the display receiver register bank
`timescale 1ns/1ps
module testbench;
  import dxr_pkg::*;
  logic        ref_clk, rst_b, reg_wr, reg_rd, reg_rvalid, power_down_pin, sync_present;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        low_power, video_oe_b, green_sync_oe_b, de_gen, sav_m, eav_m;
  logic        hs_in, vs_in, fld_in;
  dxr_status_s status_in;
  dxr_config_s config_out;
  int          n_errors, checks_done, cycles;
  logic [7:0]  rst_tab [9] = '{8'h08, 8'h80, 8'h61, 8'h04, 8'h05, 8'h00, 8'h02, 8'hD0, 8'h18};

  dxr_regs i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .power_down_pin(power_down_pin),
    .sync_present(sync_present), .status_in(status_in), .hsync_in(hs_in), .vsync_in(vs_in), .field_in(fld_in),
    .low_power(low_power), .video_oe_b(video_oe_b), .green_sync_oe_b(green_sync_oe_b),
    .config_out(config_out), .de_gen(de_gen), .active_video_start_marker(sav_m),
    .active_video_end_marker(eav_m));
  dxr_host i_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Compare and report
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_host.read(addr, d, ok);
    chk("read_valid", 16'h0001, {15'h0, ok});
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask

  // Outputs lag the cause by at most two edges, so three falling edges leave margin
  task automatic pwr_chk(input logic [2:0] exp);
    repeat (3) @(negedge ref_clk);
    chk("power_outputs", {13'h0, exp}, {13'h0, low_power, video_oe_b, green_sync_oe_b});
  endtask

  // Vsync pulse, then nh hsync pulses; eight samples of DE and markers follow the last one
  task automatic gen_run(input int nh, input logic [7:0] de_e, input logic [7:0] s_e, input logic [7:0] e_e);
    logic [7:0] de_v, s_v, e_v;
    @(negedge ref_clk);
    vs_in = 1'b1;
    @(negedge ref_clk);
    vs_in = 1'b0;
    repeat (nh) begin
      @(negedge ref_clk);
      hs_in = 1'b1;
      @(negedge ref_clk);
      hs_in = 1'b0;
    end
    for (int k = 0; k < 8; k++) begin
      @(negedge ref_clk);
      de_v[k] = de_gen;
      s_v[k]  = sav_m;
      e_v[k]  = eav_m;
    end
    chk("de_gen", {8'h00, de_e}, {8'h00, de_v});
    chk("start_marker", {8'h00, s_e}, {8'h00, s_v});
    chk("end_marker", {8'h00, e_e}, {8'h00, e_v});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Test sequence
  initial begin
    logic [1:0] fn;
    rst_b          = 1'b0;
    power_down_pin = 1'b0;
    sync_present   = 1'b1;
    status_in      = '0;
    hs_in          = 1'b0;
    vs_in          = 1'b0;
    fld_in         = 1'b0;
    n_errors       = 0;
    checks_done    = 0;
    cycles         = 0;
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;

    for (int i = 0; i < 9; i++) begin
      rd_chk("reset_value", 8'h26 + 8'(i), rst_tab[i]);
    end
    rd_chk("unmapped", 8'h31, 8'h00);
    pwr_chk(3'b000);
    $display("test reset_values done");

    for (int f = 0; f < 4; f++) begin
      fn = 2'(f);
      i_host.write(8'h26, {5'h01, fn, 1'b0});
      power_down_pin = 1'b1;
      pwr_chk({~fn[1], 1'b1, fn[0]});
      power_down_pin = 1'b0;
      pwr_chk(3'b000);
    end
    // Active-low polarity: a low pin now asserts power-down
    i_host.write(8'h26, 8'h00);
    pwr_chk(3'b110);
    power_down_pin = 1'b1;
    pwr_chk(3'b000);
    power_down_pin = 1'b0;
    i_host.write(8'h26, 8'h09);
    pwr_chk(3'b110);
    i_host.write(8'h26, 8'hFF);
    rd_chk("pwr_cfg", 8'h26, 8'h0F);
    i_host.write(8'h26, 8'h08);
    pwr_chk(3'b000);
    $display("test power_pin done");

    sync_present = 1'b0;
    pwr_chk(3'b110);
    i_host.write(8'h27, 8'h78);
    pwr_chk(3'b000);
    sync_present = 1'b1;
    rd_chk("auto_mode", 8'h27, 8'h78);
    $display("test auto_power done");

    // External master clock is assumed locked to video by its supplier
    for (int m = 0; m < 4; m++) begin
      i_host.write(8'h2E, {1'b1, 2'(m), 5'h10});
      repeat (3) @(negedge ref_clk);
      chk("config_out", {4'h0, 4'hF, 1'b1, 2'(m), 5'h10}, {4'h0, config_out});
    end
    i_host.write(8'h2E, 8'h18);
    i_host.write(8'h27, 8'h80);
    repeat (3) @(negedge ref_clk);
    chk("config_out", {4'h0, 12'h018}, {4'h0, config_out});
    i_host.write(8'h2A, 8'hFF);
    i_host.write(8'h2C, 8'hFF);
    rd_chk("line_width_high", 8'h2A, 8'h0F);
    rd_chk("screen_height_high", 8'h2C, 8'h0F);
    $display("test config done");

    // Small window: vdelay 1, hdelay 2, width 3, height 1
    i_host.write(8'h28, 8'h04);
    i_host.write(8'h29, 8'h02);
    i_host.write(8'h2A, 8'h00);
    i_host.write(8'h2B, 8'h03);
    i_host.write(8'h2C, 8'h00);
    i_host.write(8'h2D, 8'h01);
    i_host.write(8'h27, 8'h19);
    gen_run(1, 8'h1C, 8'h04, 8'h20);
    gen_run(2, 8'h00, 8'h00, 8'h00);
    fld_in = 1'b1;
    gen_run(2, 8'h1C, 8'h04, 8'h20);
    fld_in = 1'b0;
    $display("test timing done");

    status_in = {1'b1, 1'b0, 1'b1, 1'b0, 3'b101, 1'b1, 1'b0, 1'b1, 4'h9};
    i_host.write(8'h2F, 8'hFF);
    i_host.write(8'h30, 8'hFF);
    rd_chk("link_status_a", 8'h2F, 8'h55);
    rd_chk("link_status_b", 8'h30, 8'h59);
    status_in = {1'b0, 1'b1, 1'b0, 1'b1, 3'b010, 1'b0, 1'b1, 1'b0, 4'h0};
    i_host.write(8'h2F, 8'h00);
    rd_chk("link_status_a", 8'h2F, 8'h2A);
    rd_chk("link_status_b", 8'h30, 8'h20);
    $display("test status done");

    tally_and_finish();
  end
endmodule // testbench
